/* File: rtl/ddr4_wturn_pkg.sv */
// Constants and types for the write turnaround timing block
package ddr4_wturn_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LAT = 8'h04;
  localparam logic [7:0] OFF_REC = 8'h08;
  localparam logic [7:0] OFF_WTR = 8'h0C;
  localparam logic [7:0] OFF_RAS = 8'h10;
  localparam logic [7:0] OFF_FLAG = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_DBI_POS = 2;
  localparam int LAT_CWL_POS = 8;
  localparam int REC_DBI_POS = 8;
  localparam int WTR_L_POS = 8;
  localparam int FLAG_RD = 0;
  localparam int FLAG_PRE = 1;
  localparam int FLAG_RAS = 2;
  localparam int FLAG_OVL = 3;
  localparam int FLAG_OVR = 4;
  localparam int FLAG_W = 5;
  localparam int STATE_BEAT_POS = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_BL = 2'h0;
  localparam logic RST_DBI = 1'b0;
  localparam logic [4:0] RST_AL = 5'h00;
  localparam logic [4:0] RST_CWL = 5'h09;
  localparam logic [7:0] RST_TWR = 8'h0C;
  localparam logic [7:0] RST_TWR_DBI = 8'h0E;
  localparam logic [7:0] RST_TWTR_S = 8'h02;
  localparam logic [7:0] RST_TWTR_L = 8'h06;
  localparam logic [7:0] RST_TRAS = 8'h20;

  // ----------------------------------------------------------------
  // Burst field codes and cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [3:0] CLKS_FULL = 4'h4;
  localparam logic [3:0] CLKS_FIXED4 = 4'h2;
  localparam logic [3:0] BEATS_8 = 4'h8;
  localparam logic [3:0] BEATS_4 = 4'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_WR = 3'h2,
    CMD_RD = 3'h3,
    CMD_PRE = 3'h4
  } cmd_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_LAT = 2'h1,
    PH_DATA = 2'h3
  } phase_t;

endpackage : ddr4_wturn_pkg

/* File: rtl/wbuf2.sv */
// Two-entry valid/ready buffer for captured write beats
`timescale 1ns/1ps
module wbuf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset, valid gates it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : wbuf2

/* File: rtl/ddr4_wturn.sv */
// DDR4 write burst capture and post-write turnaround checking
//
// What this block does
// - Burst field 00, or 01 with A12 high: eight-beat burst.
// - Burst field 01 with A12 low: on-the-fly four-beat chop.
// - Burst field 10: fixed four-beat chop, A12 ignored.
// - Write data starts additive latency plus CAS write latency after WRITE.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module ddr4_wturn
  import ddr4_wturn_pkg::*;
#(
  parameter int DQ_W = 8,
  parameter int TMR_W = 8
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link pins from the controller
  input wire logic ck,
  input wire logic [2:0] cmd,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic a12,
  input wire logic [DQ_W-1:0] dq,
  // Captured write data
  output logic [DQ_W-1:0] wdat,
  output logic wdat_valid,
  input wire logic wdat_ready,
  // Status
  output logic burst_busy
);

  localparam int SW = DQ_W + 9;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] burst_clks(logic [1:0] m, logic a);
    return (m == BL_FIXED4) ? CLKS_FIXED4 : CLKS_FULL;
  endfunction : burst_clks

  function automatic logic [3:0] burst_beats(logic [1:0] m, logic a);
    return (m == BL_FIXED4 || (m == BL_OTF && !a)) ? BEATS_4 : BEATS_8;
  endfunction : burst_beats

  function automatic logic [TMR_W-1:0] dec(logic [TMR_W-1:0] t);
    return (t != '0) ? t - 1'b1 : t;
  endfunction : dec

  // ----------------------------------------------------------------
  // Pin synchroniser and clock edge finder
  // ----------------------------------------------------------------
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic ck_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      ck_lvl <= 1'b0;
    end else begin
      s1 <= {dq, a12, ba, bg, cmd, ck};
      s2 <= s1;
      s3 <= s2;
      if (s2[0] == s3[0]) begin
        ck_lvl <= s3[0];
      end
    end
  end

  // CK at 160 ns gives eight pclk per period, ample for three stages
  wire ck_edge = (s2[0] == s3[0]) && (s3[0] != ck_lvl);
  wire ck_rise = ck_edge && s3[0];
  wire [2:0] cmd_s = s3[3:1];
  // Bank index is group then bank, so the top two bits name the group
  wire [3:0] bank_s = {s3[5:4], s3[7:6]};
  wire [1:0] bg_s = s3[5:4];
  wire a12_s = s3[8];
  wire [DQ_W-1:0] dq_s = s3[SW-1:9];
  wire ev_act = ck_rise && cmd_s == CMD_ACT;
  wire ev_wr = ck_rise && cmd_s == CMD_WR;
  wire ev_rd = ck_rise && cmd_s == CMD_RD;
  wire ev_pre = ck_rise && cmd_s == CMD_PRE;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] bl_mode;
  logic dbi_en;
  logic [4:0] al;
  logic [4:0] cwl;
  logic [7:0] twr;
  logic [7:0] twr_dbi;
  logic [7:0] twtr_s;
  logic [7:0] twtr_l;
  logic [7:0] tras;
  logic [FLAG_W-1:0] flags;

  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_lat = paddr == OFF_LAT;
  wire hit_rec = paddr == OFF_REC;
  wire hit_wtr = paddr == OFF_WTR;
  wire hit_ras = paddr == OFF_RAS;
  wire hit_flag = paddr == OFF_FLAG;
  wire hit_state = paddr == OFF_STATE;
  wire addr_ok = hit_ctrl | hit_lat | hit_rec | hit_wtr | hit_ras
               | hit_flag | hit_state;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_mode <= RST_BL;
      dbi_en <= RST_DBI;
      al <= RST_AL;
      cwl <= RST_CWL;
      twr <= RST_TWR;
      twr_dbi <= RST_TWR_DBI;
      twtr_s <= RST_TWTR_S;
      twtr_l <= RST_TWTR_L;
      tras <= RST_TRAS;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        bl_mode <= pwdata[1:0];
        dbi_en <= pwdata[CTRL_DBI_POS];
      end
      if (hit_lat) begin
        al <= pwdata[4:0];
        cwl <= pwdata[LAT_CWL_POS +: 5];
      end
      if (hit_rec) begin
        twr <= pwdata[7:0];
        twr_dbi <= pwdata[REC_DBI_POS +: 8];
      end
      if (hit_wtr) begin
        twtr_s <= pwdata[7:0];
        twtr_l <= pwdata[WTR_L_POS +: 8];
      end
      if (hit_ras) begin
        tras <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  phase_t phase;
  logic [5:0] lat_cnt;
  logic [3:0] clk_cnt;
  logic [3:0] beats_left;
  logic [3:0] cur_bank;
  logic in_ready;

  wire [5:0] wl = {1'b0, al} + {1'b0, cwl};
  // Zero latency is not a legal setting; treat it as one clock
  wire [5:0] wl_eff = (wl == 6'h00) ? 6'h01 : wl;
  wire wr_go = ev_wr && phase == PH_IDLE;
  wire lat_done = phase == PH_LAT && ck_rise && lat_cnt == 6'h01;
  wire cap = lat_done || (phase == PH_DATA && ck_edge && beats_left != 4'h0);
  wire burst_end = phase == PH_DATA && ck_rise && clk_cnt == 4'h1;
  wire [7:0] rec_time = dbi_en ? twr_dbi : twr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_IDLE;
      lat_cnt <= 6'h00;
      clk_cnt <= 4'h0;
      beats_left <= 4'h0;
      cur_bank <= 4'h0;
    end else begin
      if (wr_go) begin
        phase <= PH_LAT;
        lat_cnt <= wl_eff;
        clk_cnt <= burst_clks(bl_mode, a12_s);
        beats_left <= burst_beats(bl_mode, a12_s);
        cur_bank <= bank_s;
      end else if (phase == PH_LAT && ck_rise) begin
        lat_cnt <= lat_cnt - 6'h01;
        if (lat_cnt == 6'h01) begin
          phase <= PH_DATA;
        end
      end else if (phase == PH_DATA && ck_rise) begin
        clk_cnt <= clk_cnt - 4'h1;
        if (clk_cnt == 4'h1) begin
          phase <= PH_IDLE;
        end
      end
      if (cap && beats_left != 4'h0) begin
        beats_left <= beats_left - 4'h1;
      end
    end
  end

  assign burst_busy = phase != PH_IDLE;

  // ----------------------------------------------------------------
  // Post-write and post-activate timers, counted in CK clocks
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] wr_tmr [16];
  logic [TMR_W-1:0] ras_tmr [16];
  logic [TMR_W-1:0] wtr_l [4];
  logic [TMR_W-1:0] wtr_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        wr_tmr[i] <= '0;
        ras_tmr[i] <= '0;
      end
      for (int i = 0; i < 4; i++) begin
        wtr_l[i] <= '0;
      end
      wtr_s <= '0;
    end else if (ck_rise) begin
      for (int i = 0; i < 16; i++) begin
        wr_tmr[i] <= dec(wr_tmr[i]);
        ras_tmr[i] <= dec(ras_tmr[i]);
      end
      for (int i = 0; i < 4; i++) begin
        wtr_l[i] <= dec(wtr_l[i]);
      end
      wtr_s <= dec(wtr_s);
      // intervals start at the rise after the last beat, or two rises later for an on-the-fly chop
      if (burst_end) begin
        wr_tmr[cur_bank] <= TMR_W'(rec_time);
        wtr_l[cur_bank[3:2]] <= TMR_W'(twtr_l);
        wtr_s <= TMR_W'(twtr_s);
      end
      if (ev_act) begin
        ras_tmr[bank_s] <= TMR_W'(tras);
      end
    end
  end

  // ----------------------------------------------------------------
  // Spacing checks and sticky flags
  // ----------------------------------------------------------------
  // Timer value one means the interval ends on this very rise
  // short spacing other group, long spacing same group
  wire rd_early = ev_rd && (burst_busy || wtr_s > TMR_W'(1)
                || wtr_l[bg_s] > TMR_W'(1));
  // write latency, burst clocks and recovery before PRECHARGE
  wire pre_wr_early = ev_pre && ((burst_busy && cur_bank == bank_s)
                    || wr_tmr[bank_s] > TMR_W'(1));
  wire pre_ras_early = ev_pre && ras_tmr[bank_s] > TMR_W'(1);
  // Link cannot stall, so a full buffer can only be reported
  wire overrun = cap && !in_ready;
  wire [FLAG_W-1:0] flag_set = {overrun, ev_wr && burst_busy,
                                pre_ras_early, pre_wr_early, rd_early};
  wire [FLAG_W-1:0] flag_clr = (wr_en && hit_flag) ?
                               pwdata[FLAG_W-1:0] : '0;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered in the setup phase
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_ctrl ? {29'h0, dbi_en, bl_mode} :
    hit_lat ? {19'h0, cwl, 3'h0, al} :
    hit_rec ? {16'h0, twr_dbi, twr} :
    hit_wtr ? {16'h0, twtr_l, twtr_s} :
    hit_ras ? {24'h0, tras} :
    hit_flag ? {27'h0, flags} :
    hit_state ? {26'h0, beats_left, phase} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Beat buffer
  // ----------------------------------------------------------------
  wbuf2 #(.W(DQ_W)) u_buf (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(cap),
    .in_ready(in_ready),
    .in_data(dq_s),
    .out_valid(wdat_valid),
    .out_ready(wdat_ready),
    .out_data(wdat)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bl8_shape: assert property (
    wr_go && (bl_mode == BL_FIXED8 || (bl_mode == BL_OTF && a12_s))
    |=> beats_left == BEATS_8 && clk_cnt == CLKS_FULL)
    else $error("eight-beat burst shape wrong");

  a_otf_chop: assert property (
    wr_go && bl_mode == BL_OTF && !a12_s
    |=> beats_left == BEATS_4 && clk_cnt == CLKS_FULL)
    else $error("on-the-fly chop shape wrong");

  a_fixed_chop: assert property (
    wr_go && bl_mode == BL_FIXED4
    |=> beats_left == BEATS_4 && clk_cnt == CLKS_FIXED4)
    else $error("fixed chop shape wrong");

  a_wl_load: assert property (
    wr_go && wl != 6'h00 |=> phase == PH_LAT && lat_cnt == $past(wl))
    else $error("write latency not AL plus CWL");

  a_pre_flag: assert property (
    pre_wr_early |=> flags[FLAG_PRE])
    else $error("early precharge not flagged");

  a_ras_flag: assert property (
    ev_pre && ras_tmr[bank_s] > TMR_W'(1) |=> flags[FLAG_RAS])
    else $error("precharge before tRAS not flagged");

  a_rec_load: assert property (
    burst_end && !dbi_en |=> wr_tmr[$past(cur_bank)] == TMR_W'($past(twr)))
    else $error("recovery timer not loaded");

  a_wtr_flag: assert property (
    ev_rd && (wtr_l[bg_s] > TMR_W'(1) || wtr_s > TMR_W'(1))
    |=> flags[FLAG_RD])
    else $error("early read not flagged");

  a_end_edge: assert property (
    burst_end |-> ck_rise && beats_left == 4'h0 ##1 phase == PH_IDLE)
    else $error("interval start not after last beat");

  a_dbi_rec: assert property (
    burst_end && dbi_en
    |=> wr_tmr[$past(cur_bank)] == TMR_W'($past(twr_dbi)))
    else $error("inversion recovery time not used");

endmodule : ddr4_wturn

/* File: testbench/ctl_model.sv */
// Memory controller model driving the link pins
`timescale 1ns/1ps
module ctl_model
  import ddr4_wturn_pkg::*;
(
  // Link pins
  output logic ck,
  output logic [2:0] cmd,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic a12,
  output logic [7:0] dq,
  // Clock enable, low while reset flushes
  input wire logic run
);
  initial begin
    ck = 1'b0;
    cmd = CMD_NOP;
    bg = 2'h0;
    ba = 2'h0;
    a12 = 1'b0;
    dq = 8'h5A;
  end

  always #80 if (run) ck = ~ck;

  // Command set at the fall, taken at the next rise
  task automatic send(input logic [2:0] c, input logic [1:0] g, b,
                      input logic a);
    @(negedge ck);
    cmd = c;
    bg = g;
    ba = b;
    a12 = a;
    @(posedge ck);
    #40;
    cmd = CMD_NOP;
    a12 = ~a;
  endtask : send

  // Returns 40 ns after the n-th rise; next command lands n+1 later
  task automatic idle(input int n);
    repeat (n) @(posedge ck);
    #40;
  endtask : idle

  // returns just after the burst end rise
  task automatic wr_burst(input logic [1:0] g, b, input logic a,
                          input int wl, n, e, input logic [7:0] base);
    send(CMD_WR, g, b, a);
    #(160 * wl - 80);
    for (int i = 0; i < n; i++) begin
      dq = base + 8'(i);
      #80;
    end
    // Released bus must not look like the last beat
    dq = ~dq;
    repeat (e - n / 2 + 1) @(posedge ck);
    #40;
  endtask : wr_burst
endmodule : ctl_model

/* File: testbench/testbench.sv */
// Self-checking bench for the write turnaround block
`timescale 1ns/1ps
module testbench;
  import ddr4_wturn_pkg::*;
  // --------
  // Signals
  // --------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ck;
  logic [2:0] cmd;
  logic [1:0] bg;
  logic [1:0] ba;
  logic a12;
  logic [7:0] dq;
  logic [7:0] wdat;
  logic wdat_valid;
  logic wdat_ready = 1'b1;
  logic burst_busy;
  logic run = 1'b0;
  logic [31:0] rd;
  logic serr;
  logic [7:0] got[$];
  int err_total = 0;
  int compares = 0;

  always #10 pclk = ~pclk;

  ddr4_wturn i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ck(ck), .cmd(cmd), .bg(bg),
    .ba(ba), .a12(a12), .dq(dq), .wdat(wdat), .wdat_valid(wdat_valid),
    .wdat_ready(wdat_ready), .burst_busy(burst_busy)
  );

  ctl_model i_ctl (
    .ck(ck), .cmd(cmd), .bg(bg), .ba(ba), .a12(a12), .dq(dq), .run(run)
  );

  always @(posedge pclk) begin
    if (wdat_valid === 1'b1 && wdat_ready === 1'b1) begin
      got.push_back(wdat);
    end
  end

  // --------
  // Shared tasks
  // --------
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      err_total++;
      summarize();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Link pins cross three flops, so give events time to land
  task automatic settle;
    repeat (12) @(posedge pclk);
  endtask : settle

  task automatic flag_is(input int pos, input logic v);
    settle();
    apb(1'b0, OFF_FLAG, 32'h0);
    check("flag", {31'h0, rd[pos]}, {31'h0, v});
    apb(1'b1, OFF_FLAG, 32'h3F);
  endtask : flag_is

  // --------
  // Scenarios
  // --------
  task automatic t_regs;
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl", rd, {29'h0, RST_DBI, RST_BL});
    apb(1'b0, OFF_STATE, 32'h0);
    check("state", rd, 32'h0);
    apb(1'b0, OFF_LAT, 32'h0);
    check("lat", rd, {19'h0, RST_CWL, 3'h0, RST_AL});
    apb(1'b0, OFF_REC, 32'h0);
    check("rec", rd, {16'h0, RST_TWR_DBI, RST_TWR});
    apb(1'b0, OFF_WTR, 32'h0);
    check("wtr", rd, {16'h0, RST_TWTR_L, RST_TWTR_S});
    apb(1'b0, OFF_RAS, 32'h0);
    check("ras", rd, {24'h0, RST_TRAS});
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    check("unmapped err", {31'h0, serr}, 32'h1);
  endtask : t_regs

  task automatic burst(input logic [1:0] bl, input logic a,
                       input int wl, n, e);
    apb(1'b1, OFF_CTRL, {30'h0, bl});
    i_ctl.wr_burst(2'h0, 2'h0, a, wl, n, e, 8'h10);
    settle();
    check("busy", {31'h0, burst_busy}, 32'h0);
    check("beats", 32'(got.size()), 32'(n));
    foreach (got[i]) check("beat", {24'h0, got[i]}, 32'(8'h10 + i));
    got.delete();
  endtask : burst

  task automatic t_modes;
    burst(BL_FIXED8, 1'b0, 9, 8, 4);
    burst(BL_OTF, 1'b1, 9, 8, 4);
    burst(BL_OTF, 1'b0, 9, 4, 4);
    burst(BL_FIXED4, 1'b1, 9, 4, 2);
    apb(1'b1, OFF_LAT, {19'h0, 5'h05, 3'h0, 5'h02});
    burst(BL_FIXED8, 1'b0, 7, 8, 4);
    apb(1'b1, OFF_LAT, {19'h0, RST_CWL, 3'h0, RST_AL});
  endtask : t_modes

  // short spacing legal only in another group
  task automatic t_wtr;
    apb(1'b1, OFF_FLAG, 32'h3F);
    i_ctl.wr_burst(2'h0, 2'h0, 1'b1, 9, 8, 4, 8'h20);
    i_ctl.idle(1);
    i_ctl.send(CMD_RD, 2'h1, 2'h0, 1'b0);
    flag_is(FLAG_RD, 1'b0);
    i_ctl.wr_burst(2'h1, 2'h0, 1'b1, 9, 8, 4, 8'h20);
    i_ctl.idle(4);
    i_ctl.send(CMD_RD, 2'h1, 2'h2, 1'b0);
    flag_is(FLAG_RD, 1'b1);
    got.delete();
  endtask : t_wtr

  task automatic t_pre;
    apb(1'b1, OFF_FLAG, 32'h3F);
    i_ctl.send(CMD_ACT, 2'h0, 2'h1, 1'b0);
    i_ctl.send(CMD_PRE, 2'h0, 2'h1, 1'b0);
    flag_is(FLAG_RAS, 1'b1);
    apb(1'b1, OFF_RAS, 32'h1);
    // Fixed chop ends two clocks early; inversion stretches recovery
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, OFF_CTRL, {29'h0, d[0], ~d[0], 1'b0});
      i_ctl.wr_burst(2'h0, 2'h1, 1'b1, 9, 4 + 4 * d, 2 + 2 * d, 8'h30);
      i_ctl.idle(11);
      i_ctl.send(CMD_PRE, 2'h0, 2'h1, 1'b0);
      flag_is(FLAG_PRE, d[0]);
    end
    apb(1'b1, OFF_CTRL, 32'h0);
    i_ctl.wr_burst(2'h0, 2'h1, 1'b1, 9, 8, 4, 8'h30);
    i_ctl.idle(10);
    i_ctl.send(CMD_PRE, 2'h0, 2'h1, 1'b0);
    flag_is(FLAG_PRE, 1'b1);
    got.delete();
  endtask : t_pre

  // Stalled consumer: two words kept, the rest refused
  task automatic t_stall;
    @(posedge pclk);
    wdat_ready <= 1'b0;
    i_ctl.wr_burst(2'h2, 2'h0, 1'b1, 9, 8, 4, 8'h40);
    check("full valid", {31'h0, wdat_valid}, 32'h1);
    flag_is(FLAG_OVR, 1'b1);
    check("stalled", 32'(got.size()), 32'h0);
    @(posedge pclk);
    wdat_ready <= 1'b1;
    settle();
    check("drained", 32'(got.size()), 32'h2);
    check("first", {24'h0, got[0]}, 32'h40);
    check("second", {24'h0, got[1]}, 32'h41);
  endtask : t_stall

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    run <= 1'b1;
    t_regs();
    t_modes();
    t_wtr();
    t_pre();
    t_stall();
    summarize();
  end
endmodule : testbench
